/* design/sar_adc_wrapper.sv */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "sar_wrap_cfg.svh"
`default_nettype none

module sar_adc_wrapper #(
  parameter int NUM_PWU = 8
) (
  input  wire logic                    clk_i,         // System clock
  input  wire logic                    rst_n_i,       // Synchronous reset, active low
  input  wire sar_wrap_pkg::apb_req_s  apb_i,         // APB request
  output sar_wrap_pkg::apb_rsp_s       apb_o,         // APB answer
  input  wire logic [2:0]              timer_trig_i,  // Timer 0..2 start pulses
  input  wire logic                    ext_line_i,    // External interrupt line pulse
  input  wire logic [NUM_PWU-1:0]      pwu_soc_a_i,   // Pulse-width unit start A
  input  wire logic [NUM_PWU-1:0]      pwu_soc_b_i,   // Pulse-width unit start B
  output sar_wrap_pkg::core_req_s      core_o,        // Analog core control
  input  wire logic [15:0]             core_data_i,   // Analog core result code
  output logic                         converter_clock_o, // Converter clock strobe
  output logic                         busy_o,        // Sampling or converting
  output logic [`NUM_INTS-1:0]         event_int_o,   // Interrupt expander lines
  output logic [`NUM_PPB-1:0]          ppb_int_o,     // Compare event per unit
  output logic [`NUM_PPB-1:0]          ppb_trip_hi_o, // High trip per unit
  output logic [`NUM_PPB-1:0]          ppb_trip_lo_o  // Low trip per unit
);
  import sar_wrap_pkg::*;

  // Lowest pending slot wins
  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) idx = 4'(i);
    end
    return idx;
  endfunction

  // Conversion length in system cycles: half cycles times ratio, halved and rounded up
  function automatic logic [11:0] conv_cycles(input logic [3:0] code, input logic res16);
    logic [15:0] prod;
    prod = 16'(res16 ? `CONV_HALF_16 : `CONV_HALF_12) * (16'(code) + 16'h0002);
    return 12'((prod + 16'h0003) >> 2);
  endfunction

  // Trigger source match for one slot
  function automatic logic trig_hit(input logic [4:0] sel, input logic [2:0] tmr,
                                    input logic ext, input logic [NUM_PWU-1:0] pa,
                                    input logic [NUM_PWU-1:0] pb);
    logic hit;
    hit = 1'b0;
    for (int t = 0; t < `NUM_TIMERS; t++) begin
      if (sel == `TRIG_TMR0 + 5'(t)) hit = tmr[t];
    end
    if (sel == `TRIG_EXT) hit = ext;
    for (int u = 0; u < NUM_PWU; u++) begin
      if (sel == `TRIG_PWU0 + 5'(2 * u)) hit = pa[u];
      if (sel == `TRIG_PWU0 + 5'(2 * u + 1)) hit = pb[u];
    end
    return hit;
  endfunction

  // Offset correction with saturation to the 16-bit range
  function automatic logic [15:0] sat16(input logic [15:0] r, input logic signed [15:0] off);
    logic signed [17:0] s;
    s = $signed({2'b00, r}) + 18'(off);
    if (s < 18'sh00000) return 16'h0000;
    if (s > 18'sh0ffff) return 16'hffff;
    return s[15:0];
  endfunction

  // Configuration and flag state
  logic [7:0]              ctl2_r, ctl2_nxt;
  logic [4:0]              intsel_r [`NUM_INTS], intsel_nxt [`NUM_INTS];
  logic [31:0]             intsoc_r, intsoc_nxt;
  slot_cfg_s               slot_r [`NUM_SLOTS], slot_nxt [`NUM_SLOTS];
  logic [`NUM_INTS-1:0]    iflag_r, iflag_nxt;
  logic [31:0]             pcfg_r [`NUM_PPB], pcfg_nxt [`NUM_PPB];
  logic [15:0]             pset_r [`NUM_PPB], pset_nxt [`NUM_PPB];
  logic [31:0]             plim_r [`NUM_PPB], plim_nxt [`NUM_PPB];
  logic [3*`NUM_PPB-1:0]   pflag_r, pflag_nxt;
  // Sequencer state
  seq_state_e              state_r, state_nxt;
  logic [11:0]             cnt_r, cnt_nxt;
  logic [3:0]              act_r, act_nxt;
  core_req_s               core_r, core_nxt;
  logic [15:0]             pend_r, pend_nxt;
  logic [15:0]             stamp_r [`NUM_SLOTS], stamp_nxt [`NUM_SLOTS];
  logic [15:0]             time_r, time_nxt;
  // Results and post-processing state
  logic [15:0]             res_r [`NUM_SLOTS], res_nxt [`NUM_SLOTS];
  logic [15:0]             perr_r [`NUM_PPB], perr_nxt [`NUM_PPB];
  logic [15:0]             pdly_r [`NUM_PPB], pdly_nxt [`NUM_PPB];
  logic [`NUM_PPB-1:0]     psign_r, psign_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  // Combinational helpers
  logic                    wr, mode_bad, sample_go, eoc, map_ok;
  logic [3:0]              next_slot;
  logic [15:0]             trig_set, res_val, corr;
  logic [`NUM_INTS-1:0]    iset;
  logic [3*`NUM_PPB-1:0]   pset_evt;
  logic [11:0]             addr;

  conv_clock_gen u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .code_i  (ctl2_r[`CTL2_DIV_MSB:0]),
    .tick_o  (converter_clock_o)
  );

  assign addr      = apb_i.paddr;
  assign wr        = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign mode_bad  = ctl2_r[`CTL2_RES16] ^ ctl2_r[`CTL2_DIFF];
  assign next_slot = first_set(pend_r);
  assign res_val   = core_r.res16 ? core_data_i : {4'h0, core_data_i[11:0]};
  assign map_ok    = (addr[1:0] == 2'b00) && (addr < `OFF_END) &&
                     ((addr <= `OFF_PPBFLG) || (addr >= `OFF_SLOT));

  // Trigger collection per slot
  always_comb begin
    for (int s = 0; s < `NUM_SLOTS; s++) begin
      trig_set[s] = trig_hit(slot_r[s].trig, timer_trig_i, ext_line_i,
                             pwu_soc_a_i, pwu_soc_b_i);
      if (wr && addr == `OFF_FORCE && apb_i.pwdata[s]) trig_set[s] = 1'b1;
      if (intsoc_r[2*s +: 2] == 2'h1 && iset[0]) trig_set[s] = 1'b1;
      if (intsoc_r[2*s +: 2] == 2'h2 && iset[1]) trig_set[s] = 1'b1;
    end
  end

  // Sequencer: one sample-and-hold, lowest pending slot first
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    act_nxt   = act_r;
    core_nxt  = core_r;
    core_nxt.start = 1'b0;
    core_nxt.res16 = ctl2_r[`CTL2_RES16];
    core_nxt.diff  = ctl2_r[`CTL2_DIFF];
    sample_go = 1'b0;
    eoc       = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (|pend_r && !mode_bad) begin
          sample_go       = 1'b1;
          act_nxt         = next_slot;
          cnt_nxt         = {3'h0, slot_r[next_slot].acq};
          core_nxt.sample = 1'b1;
          core_nxt.chan   = ctl2_r[`CTL2_DIFF] ? {slot_r[next_slot].chan[3:1], 1'b0}
                                                : slot_r[next_slot].chan;
          state_nxt       = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (cnt_r == 12'h000) begin
          core_nxt.sample = 1'b0;
          core_nxt.start  = 1'b1;
          cnt_nxt   = conv_cycles(ctl2_r[`CTL2_DIV_MSB:0], core_r.res16) - 12'h001;
          state_nxt = ST_CONVERT;
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      ST_CONVERT: begin
        if (cnt_r == 12'h000) begin
          eoc       = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Pending: a new trigger wins over the clear of the starting slot
    pend_nxt = pend_r;
    if (sample_go) pend_nxt[next_slot] = 1'b0;
    pend_nxt = pend_nxt | trig_set;
    time_nxt = time_r + 16'h0001;
    for (int s = 0; s < `NUM_SLOTS; s++) begin
      stamp_nxt[s] = (trig_set[s] && !pend_r[s]) ? time_r : stamp_r[s];
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 12'h000;
      act_r   <= 4'h0;
      core_r  <= '0;
      pend_r  <= 16'h0000;
      time_r  <= 16'h0000;
      for (int s = 0; s < `NUM_SLOTS; s++) stamp_r[s] <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      act_r   <= act_nxt;
      core_r  <= core_nxt;
      pend_r  <= pend_nxt;
      time_r  <= time_nxt;
      for (int s = 0; s < `NUM_SLOTS; s++) stamp_r[s] <= stamp_nxt[s];
    end
  end

  // Results, event lines and post-processing
  always_comb begin
    for (int s = 0; s < `NUM_SLOTS; s++) begin
      res_nxt[s] = (eoc && act_r == 4'(s)) ? res_val : res_r[s];
    end
    for (int k = 0; k < `NUM_INTS; k++) begin
      iset[k] = eoc && intsel_r[k][`INTSEL_EN] && intsel_r[k][3:0] == act_r;
    end
    corr     = 16'h0000;
    pset_evt = '0;
    for (int p = 0; p < `NUM_PPB; p++) begin
      perr_nxt[p]  = perr_r[p];
      pdly_nxt[p]  = pdly_r[p];
      psign_nxt[p] = psign_r[p];
      if (sample_go && pcfg_r[p][3:0] == next_slot) begin
        pdly_nxt[p] = time_r - stamp_r[next_slot];
      end
      if (eoc && pcfg_r[p][3:0] == act_r) begin
        corr         = sat16(res_val, pcfg_r[p][31:16]);
        perr_nxt[p]  = corr - pset_r[p];
        psign_nxt[p] = perr_nxt[p][15];
        pset_evt[3*p]     = corr > plim_r[p][15:0];
        pset_evt[3*p + 1] = corr < plim_r[p][31:16];
        pset_evt[3*p + 2] = perr_nxt[p][15] != psign_r[p];
      end
    end
  end

  // Register file writes; hardware set wins over a software clear
  always_comb begin
    ctl2_nxt   = ctl2_r;
    intsoc_nxt = intsoc_r;
    iflag_nxt  = iflag_r;
    pflag_nxt  = pflag_r;
    if (wr && addr == `OFF_CTL2) ctl2_nxt = apb_i.pwdata[7:0];
    if (wr && addr == `OFF_INTSOC) intsoc_nxt = apb_i.pwdata;
    if (wr && addr == `OFF_INTFLG) iflag_nxt = iflag_r & ~apb_i.pwdata[`NUM_INTS-1:0];
    if (wr && addr == `OFF_PPBFLG) pflag_nxt = pflag_r & ~apb_i.pwdata[3*`NUM_PPB-1:0];
    iflag_nxt = iflag_nxt | iset;
    pflag_nxt = pflag_nxt | pset_evt;
    for (int k = 0; k < `NUM_INTS; k++) begin
      intsel_nxt[k] = (wr && addr == `OFF_INTSEL + 12'(4 * k)) ? apb_i.pwdata[4:0] : intsel_r[k];
    end
    for (int s = 0; s < `NUM_SLOTS; s++) begin
      slot_nxt[s] = slot_r[s];
      if (wr && addr == `OFF_SLOT + 12'(4 * s)) begin
        slot_nxt[s].acq  = apb_i.pwdata[`SLOT_ACQ_MSB:0];
        slot_nxt[s].chan = apb_i.pwdata[`SLOT_CH_MSB:`SLOT_CH_LSB];
        slot_nxt[s].trig = apb_i.pwdata[`SLOT_TRG_MSB:`SLOT_TRG_LSB];
      end
    end
    for (int p = 0; p < `NUM_PPB; p++) begin
      pcfg_nxt[p] = pcfg_r[p];
      pset_nxt[p] = pset_r[p];
      plim_nxt[p] = plim_r[p];
      if (wr && addr == `OFF_PPB + 12'(16 * p) + {8'h00, `PPB_CFG, 2'b00}) pcfg_nxt[p] = apb_i.pwdata;
      if (wr && addr == `OFF_PPB + 12'(16 * p) + {8'h00, `PPB_SET, 2'b00}) pset_nxt[p] = apb_i.pwdata[15:0];
      if (wr && addr == `OFF_PPB + 12'(16 * p) + {8'h00, `PPB_LIM, 2'b00}) plim_nxt[p] = apb_i.pwdata;
    end
  end

  // Read data, captured in the setup cycle so it is stable in the access phase
  always_comb begin
    rdata_nxt = rdata_r;
    if (apb_i.psel && !apb_i.penable) begin
      rdata_nxt = 32'h0000_0000;
      if (addr == `OFF_CTL2) rdata_nxt = {24'h0, ctl2_r};
      if (addr == `OFF_STATUS) rdata_nxt = {24'h0, act_r, 2'b00, mode_bad, busy_o};
      if (addr == `OFF_INTFLG) rdata_nxt = 32'(iflag_r);
      if (addr == `OFF_INTSOC) rdata_nxt = intsoc_r;
      if (addr == `OFF_PEND) rdata_nxt = {16'h0, pend_r};
      if (addr == `OFF_PPBFLG) rdata_nxt = 32'(pflag_r);
      for (int k = 0; k < `NUM_INTS; k++) begin
        if (addr == `OFF_INTSEL + 12'(4 * k)) rdata_nxt = 32'(intsel_r[k]);
      end
      for (int s = 0; s < `NUM_SLOTS; s++) begin
        if (addr == `OFF_SLOT + 12'(4 * s))
          rdata_nxt = {7'h0, slot_r[s].trig, 1'b0, slot_r[s].chan, 6'h0, slot_r[s].acq};
        if (addr == `OFF_RESULT + 12'(4 * s)) rdata_nxt = {16'h0, res_r[s]};
      end
      for (int p = 0; p < `NUM_PPB; p++) begin
        if (addr == `OFF_PPB + 12'(16 * p) + {8'h00, `PPB_CFG, 2'b00}) rdata_nxt = pcfg_r[p];
        if (addr == `OFF_PPB + 12'(16 * p) + {8'h00, `PPB_SET, 2'b00}) rdata_nxt = {16'h0, pset_r[p]};
        if (addr == `OFF_PPB + 12'(16 * p) + {8'h00, `PPB_LIM, 2'b00}) rdata_nxt = plim_r[p];
        if (addr == `OFF_PPB + 12'(16 * p) + {8'h00, `PPB_STAT, 2'b00}) rdata_nxt = {pdly_r[p], perr_r[p]};
      end
    end
  end

  // Register file and result registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl2_r   <= `CTL2_RST;
      intsoc_r <= 32'h0000_0000;
      iflag_r  <= '0;
      pflag_r  <= '0;
      psign_r  <= '0;
      rdata_r  <= 32'h0000_0000;
      for (int k = 0; k < `NUM_INTS; k++) intsel_r[k] <= 5'h00;
      for (int s = 0; s < `NUM_SLOTS; s++) begin
        slot_r[s] <= '0;
        res_r[s]  <= 16'h0000;
      end
      for (int p = 0; p < `NUM_PPB; p++) begin
        pcfg_r[p] <= 32'h0000_0000;
        pset_r[p] <= 16'h0000;
        plim_r[p] <= 32'h0000_0000;
        perr_r[p] <= 16'h0000;
        pdly_r[p] <= 16'h0000;
      end
    end else begin
      ctl2_r   <= ctl2_nxt;
      intsoc_r <= intsoc_nxt;
      iflag_r  <= iflag_nxt;
      pflag_r  <= pflag_nxt;
      psign_r  <= psign_nxt;
      rdata_r  <= rdata_nxt;
      for (int k = 0; k < `NUM_INTS; k++) intsel_r[k] <= intsel_nxt[k];
      for (int s = 0; s < `NUM_SLOTS; s++) begin
        slot_r[s] <= slot_nxt[s];
        res_r[s]  <= res_nxt[s];
      end
      for (int p = 0; p < `NUM_PPB; p++) begin
        pcfg_r[p] <= pcfg_nxt[p];
        pset_r[p] <= pset_nxt[p];
        plim_r[p] <= plim_nxt[p];
        perr_r[p] <= perr_nxt[p];
        pdly_r[p] <= pdly_nxt[p];
      end
    end
  end

  // Outputs
  assign busy_o = (state_r != ST_IDLE);
  assign core_o = core_r;
  assign event_int_o = iflag_r;
  always_comb begin
    for (int p = 0; p < `NUM_PPB; p++) begin
      ppb_trip_hi_o[p] = pflag_r[3*p];
      ppb_trip_lo_o[p] = pflag_r[3*p + 1];
      ppb_int_o[p]     = |pflag_r[3*p +: 3];
    end
  end
  assign apb_o.prdata  = rdata_r;
  assign apb_o.pready  = 1'b1;
  assign apb_o.pslverr = apb_i.psel & apb_i.penable & ~map_ok;

endmodule

`default_nettype wire

/* include/sar_wrap_cfg.svh */
`ifndef SAR_WRAP_CFG_SVH
`define SAR_WRAP_CFG_SVH

// Structure sizes
`define NUM_SLOTS     16
`define NUM_INTS      4
`define NUM_PPB       4
`define NUM_TIMERS    3

// Register byte offsets
`define OFF_CTL2      12'h000
`define OFF_STATUS    12'h004
`define OFF_FORCE     12'h008
`define OFF_INTFLG    12'h00c
`define OFF_INTSEL    12'h010
`define OFF_INTSOC    12'h020
`define OFF_PEND      12'h024
`define OFF_PPBFLG    12'h028
`define OFF_SLOT      12'h040
`define OFF_RESULT    12'h080
`define OFF_PPB       12'h0c0
`define OFF_END       12'h100

// Second control register fields and reset value
`define CTL2_DIV_MSB  3
`define CTL2_RES16    6
`define CTL2_DIFF     7
`define CTL2_RST      8'h00

// Slot control word fields
`define SLOT_ACQ_MSB  8
`define SLOT_CH_LSB   15
`define SLOT_CH_MSB   18
`define SLOT_TRG_LSB  20
`define SLOT_TRG_MSB  24

// Event line select word fields
`define INTSEL_EN     4

// Post-processing word indices inside one unit
`define PPB_CFG       2'h0
`define PPB_SET       2'h1
`define PPB_LIM       2'h2
`define PPB_STAT      2'h3

// Trigger source codes
`define TRIG_SW       5'h00
`define TRIG_TMR0     5'h01
`define TRIG_EXT      5'h04
`define TRIG_PWU0     5'h05

// Conversion length in half converter clock cycles
`define CONV_HALF_16  10'd59
`define CONV_HALF_12  10'd21

`endif

/* include/sar_wrap_pkg.sv */
package sar_wrap_pkg;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  // Control toward the analog core
  typedef struct packed {
    logic       sample;
    logic       start;
    logic [3:0] chan;
    logic       diff;
    logic       res16;
  } core_req_s;

  // One conversion slot
  typedef struct packed {
    logic [4:0] trig;
    logic [3:0] chan;
    logic [8:0] acq;
  } slot_cfg_s;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;

endpackage

/* design/conv_clock_gen.sv */
`timescale 1ns/10ps
`default_nettype none

module conv_clock_gen (
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_n_i, // Synchronous reset, active low
  input  wire logic [3:0] code_i,  // Divider code, ratio (code+2)/2
  output logic            tick_o   // Converter clock strobe
);

  logic [4:0] acc_r;
  logic [4:0] acc_nxt;
  logic       tick_r;
  logic       tick_nxt;

  // Fractional accumulator gives integer and half-integer ratios
  always_comb begin
    if (acc_r >= {1'b0, code_i}) begin
      acc_nxt  = acc_r - {1'b0, code_i};
      tick_nxt = 1'b1;
    end else begin
      acc_nxt  = acc_r + 5'h02;
      tick_nxt = 1'b0;
    end
  end

  // Divider state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_r  <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule

`default_nettype wire

/* verif/sar_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_core_model (
  input  wire sar_wrap_pkg::core_req_s core_i, // Core control
  input  wire logic                    clk_i,  // System clock
  input  wire logic                    busy_i, // Wrapper busy
  output logic [15:0]                  data_o  // Result code
);
  import sar_wrap_pkg::*;
  logic [3:0]  chan_r;
  logic [15:0] junk_r = 16'ha5a5;
  // Latch channel at conversion start, noise pattern runs every cycle
  always_ff @(posedge clk_i) begin
    if (core_i.start) begin
      chan_r <= core_i.chan;
    end
    junk_r <= ~{junk_r[14:0], junk_r[15]};
  end
  // Code held only while converting, noise otherwise
  assign data_o = (busy_i && !core_i.sample) ? {4'h9, chan_r, 8'h3c} : junk_r;
endmodule
`default_nettype wire

/* verif/sar_adc_wrapper_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_chk (
  input wire logic                    clk_i,   // System clock
  input wire logic                    rst_n_i, // Reset, active low
  input wire sar_wrap_pkg::core_req_s core_o,  // Core control
  input wire logic                    busy_o   // Busy
);
  import sar_wrap_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Sequencing toward the core
  a_sample_then_start: assert property ($fell(core_o.sample) |-> core_o.start)
    else $error("no start after sampling");
  a_start_one_cycle: assert property (core_o.start |=> !core_o.start)
    else $error("start longer than one cycle");
  a_single_hold: assert property (core_o.sample |-> !core_o.start)
    else $error("sample and start together");
  a_busy_covers: assert property ((core_o.sample || core_o.start) |-> busy_o)
    else $error("busy low while active");
  a_mode_valid: assert property ($rose(core_o.sample) |-> core_o.res16 == core_o.diff)
    else $error("sampling in invalid mode");
  a_diff_even: assert property (core_o.sample && core_o.diff |-> !core_o.chan[0])
    else $error("odd channel in differential");
  a_conv_min: assert property (core_o.start |-> busy_o [*8])
    else $error("conversion too short");
  a_conv_max: assert property (core_o.start |-> ##[1:300] !busy_o)
    else $error("conversion too long");
  a_chan_stable: assert property (core_o.sample && $past(core_o.sample) |-> $stable(core_o.chan))
    else $error("channel moved in window");
  // Main scenarios
  c_conv16: cover property (core_o.start && core_o.res16);
  c_conv12: cover property (core_o.start && !core_o.res16);
  c_busy_end: cover property ($fell(busy_o));
endmodule
bind sar_adc_wrapper sar_chk u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .core_o(core_o), .busy_o(busy_o));
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/10ps
`include "sar_wrap_cfg.svh"
`default_nettype none
module tb;
  import sar_wrap_pkg::*;
  logic       clk_i, rst_n_i, ext, cclk, busy;
  apb_req_s   req;
  apb_rsp_s   rsp;
  core_req_s  core;
  logic [2:0] tmr;
  logic [7:0] pa, pb;
  logic [15:0] cdata;
  logic [31:0] rq;
  logic       re;
  logic [3:0] ch;
  logic [3:0] ev, pi, th, tl;
  int         error_cnt, tests_run, s, b;
  sar_adc_wrapper #(.NUM_PWU(8)) u_sar_adc_wrapper (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .apb_i(req), .apb_o(rsp), .timer_trig_i(tmr), .ext_line_i(ext), .pwu_soc_a_i(pa),
    .pwu_soc_b_i(pb), .core_o(core), .core_data_i(cdata), .converter_clock_o(cclk),
    .busy_o(busy), .event_int_o(ev), .ppb_int_o(pi), .ppb_trip_hi_o(th), .ppb_trip_lo_o(tl));
  sar_core_model u_sar_core_model (.core_i(core), .clk_i(clk_i), .busy_i(busy),
    .data_o(cdata));
  always #4 clk_i = ~clk_i;
  // One APB transfer, held until pready is seen
  task apb(input int w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= (w != 0);
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_i);
    req.penable <= 1'b1;
    do @(posedge clk_i); while (rsp.pready !== 1'b1);
    rq = rsp.prdata;
    re = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk_i);
  endtask
  // Mode change goes through one routine that would also load the trims
  task set_mode(input logic [7:0] v);
    apb(1, `OFF_CTL2, {24'h0, v});
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Waits for a conversion, counts sample and busy cycles
  task conv();
    int i;
    s = 0;
    b = 0;
    for (i = 0; i < 60 && busy !== 1'b1; i++) @(negedge clk_i);
    while (busy === 1'b1 && b < 400) begin
      b++;
      if (core.sample === 1'b1) begin
        s++;
        ch = core.chan;
      end
      @(negedge clk_i);
    end
  endtask
  task t_regs();
    apb(0, `OFF_CTL2, 0);
    chk(rq, 0);
    set_mode(8'hc5);
    apb(0, `OFF_CTL2, 0);
    chk(rq, 32'hc5);
    apb(1, `OFF_RESULT + 12'h004, 32'hffff);
    apb(0, `OFF_RESULT + 12'h004, 0);
    chk(rq, 0);
    apb(0, `OFF_END, 0);
    chk({31'h0, re}, 1);
    $display("test regs done");
  endtask
  task t_trig();
    for (int k = 1; k < 7; k++) begin
      set_mode(8'h00);
      apb(1, `OFF_SLOT + 12'h00c, (32'(k) << 20) | (32'h5 << 15) | 32'(k));
      tmr <= (k < 4) ? 3'(1 << (k - 1)) : 3'h0;
      ext <= (k == 4);
      pa <= {7'h0, k == 5};
      pb <= {7'h0, k == 6};
      @(posedge clk_i);
      tmr <= 3'h0;
      ext <= 1'b0;
      pa <= 8'h0;
      pb <= 8'h0;
      conv();
      chk(s, k + 1);
      chk(b, k + 1 + 11);
      chk({28'h0, ch}, 5);
      apb(0, `OFF_RESULT + 12'h00c, 0);
      chk(rq, 32'h53c);
    end
    $display("test triggers done");
  endtask
  task t_diff();
    int t;
    t = 0;
    set_mode(8'hc2);
    apb(1, `OFF_SLOT, (32'h7 << 15) | 32'h9);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      t += int'(cclk === 1'b1);
    end
    chk(t, 10);
    apb(1, `OFF_FORCE, 1);
    conv();
    chk(s, 10);
    chk(b, 10 + 59);
    chk({28'h0, ch}, 6);
    apb(0, `OFF_RESULT, 0);
    chk(rq, 32'h963c);
    $display("test differential done");
  endtask
  task t_invalid();
    set_mode(8'h40);
    apb(1, `OFF_FORCE, 2);
    repeat (10) @(negedge clk_i);
    chk({31'h0, busy}, 0);
    apb(0, `OFF_STATUS, 0);
    chk(rq & 32'h3, 2);
    apb(0, `OFF_PEND, 0);
    chk(rq, 2);
    set_mode(8'h00);
    conv();
    chk(s, 1);
    $display("test invalid mode done");
  endtask
  // Event line, flag-chained start and post-processing on slot 2
  task t_post();
    apb(1, `OFF_PPBFLG, 32'hfff);
    chk({28'h0, pi}, 0);
    apb(1, `OFF_SLOT + 12'h008, (32'h4 << 15) | 32'h1);
    apb(1, `OFF_INTSEL, 32'h12);
    apb(1, `OFF_INTSOC, 32'h400);
    apb(1, `OFF_PPB, 32'h0010_0002);
    apb(1, `OFF_PPB + 12'h004, 32'h400);
    apb(1, `OFF_PPB + 12'h008, 32'h0100_0440);
    apb(1, `OFF_FORCE, 32'h4);
    conv();
    chk(s, 2);
    chk({28'h0, ev}, 1);
    chk({28'h0, th}, 1);
    chk({28'h0, tl}, 0);
    conv();
    chk(s, 1);
    apb(0, `OFF_RESULT + 12'h014, 0);
    chk(rq, 32'h3c);
    apb(0, `OFF_RESULT + 12'h008, 0);
    chk(rq, 32'h43c);
    apb(0, `OFF_PPB + 12'h00c, 0);
    chk(rq, 32'h0001_004c);
    apb(0, `OFF_PPBFLG, 0);
    chk(rq, 32'h5);
    apb(1, `OFF_INTFLG, 32'h1);
    apb(1, `OFF_PPBFLG, 32'hfff);
    chk({28'h0, ev}, 0);
    chk({28'h0, pi}, 0);
    $display("test post-processing done");
  endtask
  task final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #60000;
    error_cnt++;
    final_report();
  end
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    req = '0;
    tmr = 3'h0;
    ext = 1'b0;
    pa = 8'h0;
    pb = 8'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_trig();
    t_diff();
    t_invalid();
    t_post();
    final_report();
  end
endmodule
`default_nettype wire
